// *** verilog/flash_array_program_erase_seq.sv ***
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "flash_seq_map.svh"
module flash_array_program_erase_seq (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// low power modes
	input wire logic wait_mode_in,
	input wire logic stop_mode_in,
	// array controls
	output logic pump_out,
	output logic erase_out,
	output logic bulk_out,
	output logic program_out,
	output logic latch_en_out,
	output logic byte_wr_out,
	output logic [15:0] byte_addr_out,
	output logic [7:0] byte_data_out
);
	// ---------------------------------------------
	// state
	// ---------------------------------------------
	flash_seq_pkg::seq_state_t st_r, st_nxt;
	flash_seq_pkg::ctrl_t ctrl_r, ctrl_nxt;
	flash_seq_pkg::array_op_t op_r, op_nxt;
	logic [7:0] prot_r, prot_nxt;
	logic [15:0] arm_addr_r, arm_addr_nxt;
	logic row_fail_r, row_fail_nxt;
	logic refused_r, refused_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic standby;
	logic wr_acc, rd_acc;
	logic [15:0] prot_start;
	logic addr_prot;
	assign standby = wait_mode_in | stop_mode_in;
	assign wr_acc = psel_in & penable_in & pwrite_in & ~pready_r;
	assign rd_acc = psel_in & penable_in & ~pwrite_in & ~pready_r;
	assign prot_start = {1'b1, prot_r, 7'h00};
	assign addr_prot = (prot_r != `PROT_NONE) && (arm_addr_r >= prot_start);
	// ---------------------------------------------
	// sequence and register logic
	// ---------------------------------------------
	always_comb begin
		logic [3:0] w;
		w = pwdata_in[3:0];
		st_nxt = st_r;
		ctrl_nxt = ctrl_r;
		op_nxt = op_r;
		op_nxt.wr = 1'b0;
		prot_nxt = prot_r;
		arm_addr_nxt = arm_addr_r;
		row_fail_nxt = row_fail_r;
		refused_nxt = refused_r;
		prdata_nxt = 32'h0000_0000;
		pready_nxt = psel_in & penable_in & ~pready_r;
		pslverr_nxt = 1'b0;
		if (wr_acc) begin
			case (paddr_in)
			`CTRL_OFS: begin
				// selects settle before the pump check; a cleared select leaves pump_on set until the pump bit is written 0
				if (w[`CTRL_WRITE] && w[`CTRL_WIPE]) begin
					refused_nxt = 1'b1; // see RULE_23
				end else begin
					if (!(w[`CTRL_WRITE] && ctrl_r.wipe))
						ctrl_nxt.write_sel = w[`CTRL_WRITE]; // see RULE_23
					if (!(w[`CTRL_WIPE] && ctrl_r.write_sel))
						ctrl_nxt.wipe = w[`CTRL_WIPE]; // see RULE_23
				end
				ctrl_nxt.bulk = w[`CTRL_BULK];
				if (!w[`CTRL_PUMP]) begin
					ctrl_nxt.pump_on = 1'b0;
				end else if (!ctrl_r.pump_on) begin
					// see RULE_22 see RULE_24 see RULE_25
					if (st_r == flash_seq_pkg::ST_ARMED && !addr_prot &&
						(ctrl_nxt.write_sel || ctrl_nxt.wipe)) begin
						ctrl_nxt.pump_on = 1'b1;
						st_nxt = flash_seq_pkg::ST_PUMPING;
					end else begin
						refused_nxt = 1'b1;
					end
				end
				if (st_r == flash_seq_pkg::ST_IDLE &&
					(w[`CTRL_WRITE] ^ w[`CTRL_WIPE]))
					st_nxt = flash_seq_pkg::ST_SELECTED;
				if (!w[`CTRL_WRITE] && !w[`CTRL_WIPE] && !w[`CTRL_PUMP])
					st_nxt = flash_seq_pkg::ST_IDLE;
			end
			`PROT_OFS: prot_nxt = pwdata_in[7:0];
			`STAT_OFS: begin
				refused_nxt = refused_r & ~pwdata_in[0];
				row_fail_nxt = row_fail_r & ~pwdata_in[1];
			end
			`ARR_OFS: begin
				if (st_r == flash_seq_pkg::ST_PROT_READ) begin
					arm_addr_nxt = pwdata_in[31:16];
					// see RULE_02
					if (ctrl_r.wipe && ctrl_r.bulk && prot_r != `PROT_NONE) begin
						refused_nxt = 1'b1;
						st_nxt = flash_seq_pkg::ST_IDLE;
					end else begin
						st_nxt = flash_seq_pkg::ST_ARMED;
					end
				end else if (st_r == flash_seq_pkg::ST_PUMPING &&
					ctrl_r.write_sel) begin
					// see RULE_09 see RULE_11
					if (pwdata_in[31:22] != arm_addr_r[15:`ROW_BITS]) begin
						row_fail_nxt = 1'b1;
					end else begin
						op_nxt.wr = 1'b1;
						op_nxt.addr = pwdata_in[31:16];
						op_nxt.data = pwdata_in[7:0];
					end
				end
			end
			default: pslverr_nxt = 1'b1;
			endcase
		end else if (rd_acc) begin
			case (paddr_in)
			`CTRL_OFS: prdata_nxt = {28'h0000000, ctrl_r};
			`PROT_OFS: begin
				prdata_nxt = {24'h000000, prot_r};
				if (st_r == flash_seq_pkg::ST_SELECTED)
					st_nxt = flash_seq_pkg::ST_PROT_READ;
			end
			`STAT_OFS: prdata_nxt = {24'h000000, 1'b0, st_r,
				standby, 1'b0, row_fail_r, refused_r};
			`ARR_OFS: prdata_nxt = {arm_addr_r, 16'h0000};
			default: pslverr_nxt = 1'b1;
			endcase
		end
	end
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r <= flash_seq_pkg::ST_IDLE;
			ctrl_r <= '0;
			op_r <= '0;
			prot_r <= `PROT_RST;
			arm_addr_r <= 16'h0000;
			row_fail_r <= 1'b0;
			refused_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ctrl_r <= ctrl_nxt;
			op_r <= op_nxt;
			prot_r <= prot_nxt;
			arm_addr_r <= arm_addr_nxt;
			row_fail_r <= row_fail_nxt;
			refused_r <= refused_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end
	// ---------------------------------------------
	// array drive, forced idle in standby
	// ---------------------------------------------
	logic pump_r, erase_r, bulk_r, prog_r, latch_r, bwr_r;
	logic [15:0] baddr_r;
	logic [7:0] bdata_r;
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pump_r <= 1'b0;
			erase_r <= 1'b0;
			bulk_r <= 1'b0;
			prog_r <= 1'b0;
			latch_r <= 1'b0;
			bwr_r <= 1'b0;
			baddr_r <= 16'h0000;
			bdata_r <= 8'h00;
		end else begin
			// see RULE_19 see RULE_20 see RULE_21
			pump_r <= ctrl_nxt.pump_on & ~standby;
			erase_r <= ctrl_nxt.wipe & ~standby;
			bulk_r <= ctrl_nxt.wipe & ctrl_nxt.bulk & ~standby;
			prog_r <= ctrl_nxt.write_sel & ~standby;
			latch_r <= ctrl_nxt.write_sel & ~standby; // see RULE_11
			bwr_r <= op_nxt.wr & ~standby;
			baddr_r <= standby ? 16'h0000 : op_nxt.addr;
			bdata_r <= standby ? 8'h00 : op_nxt.data;
		end
	end
	assign pump_out = pump_r;
	assign erase_out = erase_r;
	assign bulk_out = bulk_r;
	assign program_out = prog_r;
	assign latch_en_out = latch_r;
	assign byte_wr_out = bwr_r;
	assign byte_addr_out = baddr_r;
	assign byte_data_out = bdata_r;
	assign prdata_out = prdata_r;
	assign pready_out = pready_r;
	assign pslverr_out = pslverr_r;
	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	a_sel_interlock: assert property ( // see RULE_23
		@(posedge clk_sys_in) disable iff (!nrst_in)
		!(ctrl_r.write_sel && ctrl_r.wipe))
		else $error("both selects set");
	a_pump_needs_sel: assert property ( // see RULE_22
		@(posedge clk_sys_in) disable iff (!nrst_in)
		$rose(ctrl_r.pump_on) |->
		$past(st_r) == flash_seq_pkg::ST_ARMED)
		else $error("pump set outside armed state");
	a_pump_early: assert property ( // see RULE_25
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(wr_acc && paddr_in == `CTRL_OFS && pwdata_in[`CTRL_PUMP] &&
		st_r != flash_seq_pkg::ST_ARMED && !ctrl_r.pump_on)
		|=> !ctrl_r.pump_on)
		else $error("early pump accepted");
	a_prot_block: assert property ( // see RULE_24
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(addr_prot && !ctrl_r.pump_on) |=> !ctrl_r.pump_on)
		else $error("pump on protected range");
	a_bulk_refuse: assert property ( // see RULE_02
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(wr_acc && paddr_in == `ARR_OFS &&
		st_r == flash_seq_pkg::ST_PROT_READ && ctrl_r.wipe &&
		ctrl_r.bulk && prot_r != `PROT_NONE)
		|=> st_r == flash_seq_pkg::ST_IDLE && refused_r)
		else $error("bulk wipe not refused");
	a_row_fail: assert property ( // see RULE_09
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(wr_acc && paddr_in == `ARR_OFS &&
		st_r == flash_seq_pkg::ST_PUMPING && ctrl_r.write_sel &&
		pwdata_in[31:22] != arm_addr_r[15:`ROW_BITS])
		|=> !byte_wr_out && row_fail_r)
		else $error("cross row write");
	a_byte_in_row: assert property ( // see RULE_09
		@(posedge clk_sys_in) disable iff (!nrst_in)
		byte_wr_out |->
		byte_addr_out[15:`ROW_BITS] == arm_addr_r[15:`ROW_BITS])
		else $error("byte outside armed row");
	a_byte_needs_pump: assert property ( // see RULE_11
		@(posedge clk_sys_in) disable iff (!nrst_in)
		byte_wr_out |-> pump_out && program_out && latch_en_out)
		else $error("byte strobe without write mode");
	a_latch_prog: assert property ( // see RULE_11
		@(posedge clk_sys_in) disable iff (!nrst_in)
		latch_en_out == program_out)
		else $error("latch enable apart from write select");
	a_bulk_with_erase: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		bulk_out |-> erase_out)
		else $error("bulk line without wipe line");
	a_pump_state: assert property ( // see RULE_25
		@(posedge clk_sys_in) disable iff (!nrst_in)
		ctrl_r.pump_on |-> st_r == flash_seq_pkg::ST_PUMPING)
		else $error("pump on outside pumping state");
	a_pump_unprot: assert property ( // see RULE_24
		@(posedge clk_sys_in) disable iff (!nrst_in)
		$rose(ctrl_r.pump_on) |-> !$past(addr_prot))
		else $error("pump raised on protected address");
	a_standby_idle: assert property ( // see RULE_21
		@(posedge clk_sys_in) disable iff (!nrst_in)
		$past(standby) |->
		!pump_out && !erase_out && !program_out && !byte_wr_out)
		else $error("array active in standby");
	a_standby_quiet: assert property ( // see RULE_19 see RULE_20
		@(posedge clk_sys_in) disable iff (!nrst_in)
		$past(standby) |-> !bulk_out && !latch_en_out &&
		byte_addr_out == 16'h0000 && byte_data_out == 8'h00)
		else $error("array lines driven in standby");
	a_pready_pulse: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		pready_out |=> !pready_out)
		else $error("pready longer than a cycle");
	a_ready_answer: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(psel_in && penable_in && !pready_out) |=> pready_out)
		else $error("access not answered");
	a_slverr_ready: assert property (
		@(posedge clk_sys_in) disable iff (!nrst_in)
		pslverr_out |-> pready_out)
		else $error("error without ready");
	a_refuse_sticky: assert property ( // see RULE_25
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(refused_r && !(wr_acc && paddr_in == `STAT_OFS && pwdata_in[0]))
		|=> refused_r)
		else $error("refused flag lost");
	// ---------------------------------------------
	// cover points
	// ---------------------------------------------
	c_pump: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
		$rose(pump_out));
	c_byte: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
		byte_wr_out);
	c_refuse: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
		$rose(refused_r));
	c_row_fail: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
		$rose(row_fail_r));
	c_standby: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
		standby && ctrl_r.pump_on);
endmodule

// *** pkg/flash_seq_map.svh ***
// What this block and its host must do
// RULE_01 - host: selects, protect read, arming write
// RULE_02 - bulk wipe refused unless protect byte ff; checked only at the arming write, not when a later CTRL write sets bulk
// RULE_03 - host waits setup delay before pump
// RULE_04 - host bulk hold, deselect, release wait
// RULE_05 - host waits recovery before normal read
// RULE_06 - host page wipe arming sequence
// RULE_07 - host page hold then release wait
// RULE_08 - host picks longer page hold when cycling
// RULE_09 - writes outside the armed row fail
// RULE_10 - host writes only wiped bytes
// RULE_11 - write select enables address/data latching
// RULE_12 - host byte write spacing and setup
// RULE_13 - host ends row write in order
// RULE_14 - host keeps byte interval under maximum
// RULE_15 - host limits cumulative pump time per row
// RULE_16 - host runs code from another array
// RULE_17 - host keeps step order, avoids array
// RULE_18 - host disables interrupts during operations
// RULE_19 - wait mode suspends operation into standby
// RULE_20 - stop mode suspends operation into standby
// RULE_21 - standby drives all array controls inactive
// RULE_22 - pump only with select and sequence
// RULE_23 - write and wipe selects interlocked
// RULE_24 - protected address blocks pump on
// RULE_25 - state machine ignores early pump request
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define CTRL_OFS 12'h000
`define PROT_OFS 12'h004
`define STAT_OFS 12'h008
`define ARR_OFS 12'h00c
`define CTRL_PUMP 3
`define CTRL_BULK 2
`define CTRL_WIPE 1
`define CTRL_WRITE 0
`define PROT_RST 8'hff
`define PROT_NONE 8'hff
`define ROW_BITS 6
// host wait counts in 4 ns bus clocks
`define SETUP_DELAY_CYC 2500
`define WRITE_SETUP_CYC 1250
`define BYTE_WRITE_CYC 7500
`define RELEASE_DELAY_CYC 1250
`define BULK_RELEASE_CYC 25000
`define READ_RECOVERY_CYC 250
// wipe hold cut short for simulation; nothing here times it
`define WIPE_HOLD_CYC 500
`endif

// *** pkg/flash_seq_pkg.sv ***
package flash_seq_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SELECTED, ST_PROT_READ, ST_ARMED, ST_PUMPING
	} seq_state_t;
	typedef struct packed {
		logic pump_on;
		logic bulk;
		logic wipe;
		logic write_sel;
	} ctrl_t;
	typedef struct packed {
		logic wr;
		logic [15:0] addr;
		logic [7:0] data;
	} array_op_t;
endpackage

// *** sim/host_cpu_model.sv ***
`timescale 1ns/1ns
`include "flash_seq_map.svh"
module host_cpu_model #(
	parameter int SETUP_CYC = `SETUP_DELAY_CYC,
	parameter int BYTE_CYC = `BYTE_WRITE_CYC
) (
	// apb master side
	input wire logic clk_in,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in,
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [11:0] paddr_out,
	output logic [31:0] pwdata_out
);
	logic [31:0] rd;
	logic er;
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 12'h000;
		pwdata_out = 32'h0;
	end
	// register traffic only, no fetch or interrupt
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		penable_out <= 1'b1;
		@(posedge clk_in);
		while (pready_in !== 1'b1)
			@(posedge clk_in);
		rd = prdata_in;
		er = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
	endtask
	// select, protect read, arming write, then pump after setup delay
	task automatic seq(input logic [3:0] sel, input logic [15:0] a);
		xfer(1'b1, `CTRL_OFS, {28'h0, sel});
		xfer(1'b0, `PROT_OFS, 32'h0);
		xfer(1'b1, `ARR_OFS, {a, 16'h0000});
		repeat (SETUP_CYC) @(posedge clk_in);
		xfer(1'b1, `CTRL_OFS, {28'h0, sel | 4'h8});
	endtask
	// deselect first, pump off only after the release delay
	task automatic done(input int rel);
		repeat (`WIPE_HOLD_CYC) @(posedge clk_in);
		xfer(1'b1, `CTRL_OFS, 32'h8);
		repeat (rel) @(posedge clk_in);
		xfer(1'b1, `CTRL_OFS, 32'h0);
		repeat (`READ_RECOVERY_CYC) @(posedge clk_in);
	endtask
	task automatic wbyte(input logic [15:0] a, input logic [7:0] d);
		xfer(1'b1, `ARR_OFS, {a, 8'h00, d});
		repeat (BYTE_CYC) @(posedge clk_in);
	endtask
endmodule

// *** sim/flash_array_program_erase_seq_tb.sv ***
`timescale 1ns/1ns
`include "flash_seq_map.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
n_errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module flash_array_program_erase_seq_tb;
	logic clk_sys_in, nrst_in, wm, sm, psel, pen, pwr, rdy, err;
	logic pump, ers, bulk, prog, lat, bwr;
	logic [11:0] pa;
	logic [31:0] pwd, prd;
	logic [15:0] ba, a;
	logic [7:0] bd, p;
	logic [23:0] exq[$], gotq[$];
	int n_errors, num_checks, cyc;
	flash_array_program_erase_seq DUT (.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
		.pready_out(rdy), .pslverr_out(err), .wait_mode_in(wm),
		.stop_mode_in(sm), .pump_out(pump), .erase_out(ers),
		.bulk_out(bulk), .program_out(prog), .latch_en_out(lat),
		.byte_wr_out(bwr), .byte_addr_out(ba), .byte_data_out(bd));
	host_cpu_model host (.clk_in(clk_sys_in), .prdata_in(prd),
		.pready_in(rdy), .pslverr_in(err), .psel_out(psel),
		.penable_out(pen), .pwrite_out(pwr), .paddr_out(pa),
		.pwdata_out(pwd));
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		cyc++;
		if (bwr === 1'b1)
			gotq.push_back({ba, bd});
		if (cyc == 90000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// read status, then write one to clear both flags
	task automatic stat(input logic [1:0] e);
		host.xfer(1'b0, `STAT_OFS, 32'h0);
		`CHK("status", e, host.rd[1:0])
		host.xfer(1'b1, `STAT_OFS, 32'h3);
	endtask
	initial begin
		nrst_in = 1'b0;
		wm = 1'b0;
		sm = 1'b0;
		void'($urandom(32'h2ea035ac));
		repeat (12) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		@(posedge clk_sys_in);
		`CHK("outs", 6'h0, {pump, ers, bulk, prog, lat, bwr})
		host.xfer(1'b0, `PROT_OFS, 32'h0);
		`CHK("prot", `PROT_RST, host.rd[7:0])
		host.xfer(1'b0, 12'h010, 32'h0);
		`CHK("slverr", 1'b1, host.er)
		host.xfer(1'b1, `CTRL_OFS, 32'h2);
		host.xfer(1'b1, `CTRL_OFS, 32'ha);
		`CHK("early", 1'b0, pump)
		stat(2'b01);
		host.xfer(1'b1, `CTRL_OFS, 32'h3);
		`CHK("both", 1'b0, ers & prog)
		stat(2'b01);
		host.xfer(1'b1, `CTRL_OFS, 32'h0);
		for (int i = 0; i < 2; i++) begin
			p = i ? 8'($urandom % 255) : 8'h00;
			host.xfer(1'b1, `PROT_OFS, {24'h0, p});
			host.seq(i ? 4'h6 : 4'h2, 16'h8000);
			`CHK("prot_pump", 1'b0, pump)
			stat(2'b01);
			host.xfer(1'b1, `CTRL_OFS, 32'h0);
		end
		host.xfer(1'b1, `PROT_OFS, 32'hff);
		host.seq(4'h2, 16'h8100);
		`CHK("page", 3'b110, {pump, ers, bulk})
		for (int i = 0; i < 2; i++) begin
			{wm, sm} <= i ? 2'b01 : 2'b10;
			repeat (2) @(posedge clk_sys_in);
			`CHK("standby", 6'h0, {pump, ers, bulk, prog, lat, bwr})
			{wm, sm} <= 2'b00;
			repeat (2) @(posedge clk_sys_in);
			`CHK("resume", 1'b1, pump)
		end
		host.done(`RELEASE_DELAY_CYC);
		`CHK("page_end", 2'b00, {pump, ers})
		host.seq(4'h6, 16'h9000);
		`CHK("bulk", 3'b111, {pump, ers, bulk})
		host.done(`BULK_RELEASE_CYC);
		host.seq(4'h1, 16'h8040);
		`CHK("row", 3'b101, {pump, ers, prog})
		`CHK("latch", 1'b1, lat)
		repeat (`WRITE_SETUP_CYC) @(posedge clk_sys_in);
		for (int k = 0; k < 3; k++) begin
			// one byte in each of the first three quarter rows, so every target is still wiped
			a = 16'h8040 + 16'(k * 16) + 16'($urandom % 16);
			p = 8'($urandom);
			exq.push_back({a, p});
			host.wbyte(a, p);
		end
		host.wbyte(16'h8080, 8'h5a);
		stat(2'b10);
		host.done(`RELEASE_DELAY_CYC);
		`CHK("bytes", exq.size(), gotq.size())
		while (exq.size() > 0 && gotq.size() > 0)
			`CHK("byte", exq.pop_front(), gotq.pop_front())
		conclude();
	end
endmodule
